// *** t16_access.sv ***
// Contract
// - The timer 3 counter is readable and writable through a low-byte and a high-byte location.
// - Sixteen-bit values pass through an 8-bit high-byte latch so both halves move as one unit.
// - One latch is shared by every 16-bit register of the block.
// - A counter write suppresses the compare match on the next timer tick for timer 3 compare A, the only channel with a match output.
// - I/O-port accesses reach offsets 0x00 to 0x3F.
// - An I/O register reached through data space sits at its I/O offset plus 0x20.
// - Registers from data address 0x60 up answer only data-space accesses.
// - Timer 1 compare A low sits at I/O offset 0x2A, data 0x4A, its high byte next.
`timescale 1ns/1ps
`default_nettype none
module t16_access #(
  parameter int W = 16
) (
  // Clock, reset, enable
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // CPU byte access
  input  wire logic [7:0]   bus_addr,
  input  wire logic         bus_io,
  input  wire logic         bus_wr,
  input  wire logic         bus_rd,
  input  wire logic [7:0]   bus_wdata,
  output logic      [7:0]   bus_rdata_r,
  output logic              bus_rvalid_r,
  // Timer 3
  input  wire logic         t3_tick,
  output logic      [W-1:0] t3_count_r,
  output logic              t3_match_a_r,
  // Timer 1 and timer 3 compare values
  output logic      [W-1:0] t1_cmp_a_r,
  output logic      [W-1:0] t1_cmp_b_r,
  output logic      [W-1:0] t1_cmp_c_r,
  output logic      [W-1:0] t3_cmp_a_r
);
  import t16_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [7:0]               temp;
    logic [W-1:0]             cnt;
    logic [NUM_CMP-1:0][W-1:0] cmp;
    logic                     blk;
    logic [7:0]               rdata;
    logic                     rvalid;
  } t16_st_t;

  t16_st_t st_r;
  t16_st_t st_nxt;

  // ****************************************
  // Address decode
  // ****************************************
  localparam logic [NUM_CMP-1:0][7:0] CMP_LO = {
    DA_T3_CMP_A_LO,
    DA_T1_CMP_C_LO,
    8'(IO_T1_CMP_B_LO + IO_DATA_OFS),
    8'(IO_T1_CMP_A_LO + IO_DATA_OFS)
  };
  localparam logic [NUM_CMP-1:0][7:0] CMP_HI = {
    DA_T3_CMP_A_HI,
    DA_T1_CMP_C_HI,
    8'(IO_T1_CMP_B_HI + IO_DATA_OFS),
    8'(IO_T1_CMP_A_HI + IO_DATA_OFS)
  };

  logic [7:0] eff_addr;
  logic       acc_ok;

  always_comb begin
    // I/O instructions see offsets only up to the I/O limit
    eff_addr = bus_io ? 8'(bus_addr + IO_DATA_OFS) : bus_addr;
    acc_ok   = !bus_io || (bus_addr <= IO_SPACE_MAX);
    // Extended region is never reached by I/O instructions
    if (bus_io && (eff_addr >= EXT_BASE)) begin
      acc_ok = 1'b0;
    end
  end

  t16_acc_t        cnt_acc;
  t16_acc_t        cmp_acc [NUM_CMP];

  always_comb begin
    cnt_acc = T16_ACC_NONE;
    if (acc_ok && (eff_addr == DA_T3_CNT_LO)) begin
      cnt_acc = T16_ACC_LO;
    end else if (acc_ok && (eff_addr == DA_T3_CNT_HI)) begin
      cnt_acc = T16_ACC_HI;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_dec
      always_comb begin
        cmp_acc[g] = T16_ACC_NONE;
        if (acc_ok && (eff_addr == CMP_LO[g])) begin
          cmp_acc[g] = T16_ACC_LO;
        end else if (acc_ok && (eff_addr == CMP_HI[g])) begin
          cmp_acc[g] = T16_ACC_HI;
        end
      end
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt        = st_r;
    st_nxt.rvalid = bus_rd;
    st_nxt.rdata  = RST_BYTE;

    // Counting; a tick consumes any pending suppression
    if (t3_tick) begin
      st_nxt.cnt = st_r.cnt + 1'b1;
      st_nxt.blk = 1'b0;
    end

    // Counter access
    case (cnt_acc)
      T16_ACC_LO: begin
        if (bus_wr) begin
          st_nxt.cnt = {st_r.temp, bus_wdata};
          st_nxt.blk = 1'b1;
        end else if (bus_rd) begin
          st_nxt.rdata = st_r.cnt[7:0];
          st_nxt.temp  = st_r.cnt[W-1:8];
        end
      end
      T16_ACC_HI: begin
        if (bus_wr) begin
          st_nxt.temp = bus_wdata;
        end else if (bus_rd) begin
          st_nxt.rdata = st_r.temp;
        end
      end
      T16_ACC_NONE: begin
      end
      default: begin
      end
    endcase

    // Compare register access, same shared latch
    for (int i = 0; i < NUM_CMP; i++) begin
      case (cmp_acc[i])
        T16_ACC_LO: begin
          if (bus_wr) begin
            st_nxt.cmp[i] = {st_r.temp, bus_wdata};
          end else if (bus_rd) begin
            st_nxt.rdata = st_r.cmp[i][7:0];
            st_nxt.temp  = st_r.cmp[i][W-1:8];
          end
        end
        T16_ACC_HI: begin
          if (bus_wr) begin
            st_nxt.temp = bus_wdata;
          end else if (bus_rd) begin
            st_nxt.rdata = st_r.temp;
          end
        end
        T16_ACC_NONE: begin
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r.temp   <= RST_BYTE;
      st_r.cnt    <= RST_WORD;
      st_r.cmp    <= '0;
      st_r.blk    <= 1'b0;
      st_r.rdata  <= RST_BYTE;
      st_r.rvalid <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // Timer 3 compare A
  // ****************************************
  t16_cmp #(
    .W (W)
  ) u_t3_cmp_a (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .tick     (t3_tick),
    .count    (st_r.cnt),
    .cmp      (st_r.cmp[CMP_T3_A]),
    .blk      (st_r.blk),
    .match_r  (t3_match_a_r)
  );

  assign bus_rdata_r  = st_r.rdata;
  assign bus_rvalid_r = st_r.rvalid;
  assign t3_count_r   = st_r.cnt;
  assign t1_cmp_a_r   = st_r.cmp[CMP_T1_A];
  assign t1_cmp_b_r   = st_r.cmp[CMP_T1_B];
  assign t1_cmp_c_r   = st_r.cmp[CMP_T1_C];
  assign t3_cmp_a_r   = st_r.cmp[CMP_T3_A];

endmodule
`default_nettype wire

// *** t16_pkg.sv ***
`default_nettype none
package t16_pkg;

  // ****************************************
  // Access space
  // ****************************************
  localparam logic [7:0] IO_SPACE_MAX = 8'h3F;
  localparam logic [7:0] IO_DATA_OFS  = 8'h20;
  localparam logic [7:0] EXT_BASE     = 8'h60;

  // ****************************************
  // Register offsets (I/O offsets for I/O space, data addresses otherwise)
  // ****************************************
  localparam logic [7:0] IO_T1_CMP_B_LO = 8'h28;
  localparam logic [7:0] IO_T1_CMP_B_HI = 8'h29;
  localparam logic [7:0] IO_T1_CMP_A_LO = 8'h2A;
  localparam logic [7:0] IO_T1_CMP_A_HI = 8'h2B;
  localparam logic [7:0] DA_T1_CMP_C_LO = 8'h78;
  localparam logic [7:0] DA_T1_CMP_C_HI = 8'h79;
  localparam logic [7:0] DA_T3_CMP_A_LO = 8'h86;
  localparam logic [7:0] DA_T3_CMP_A_HI = 8'h87;
  localparam logic [7:0] DA_T3_CNT_LO   = 8'h88;
  localparam logic [7:0] DA_T3_CNT_HI   = 8'h89;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ****************************************
  // Compare register indices
  // ****************************************
  localparam int NUM_CMP   = 4;
  localparam int CMP_T1_A  = 0;
  localparam int CMP_T1_B  = 1;
  localparam int CMP_T1_C  = 2;
  localparam int CMP_T3_A  = 3;

  typedef enum logic [1:0] {
    T16_ACC_NONE,
    T16_ACC_LO,
    T16_ACC_HI
  } t16_acc_t;

endpackage
`default_nettype wire

// *** t16_cmp.sv ***
`timescale 1ns/1ps
`default_nettype none
module t16_cmp #(
  parameter int W = 16
) (
  // Clock, reset and enable
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Timer side
  input  wire logic         tick,
  input  wire logic [W-1:0] count,
  input  wire logic [W-1:0] cmp,
  input  wire logic         blk,
  output logic              match_r
);
  import t16_pkg::*;

  typedef struct packed {
    logic match;
  } t16_cmp_st_t;

  t16_cmp_st_t st_r;
  t16_cmp_st_t st_nxt;

  always_comb begin
    st_nxt       = st_r;
    // Match pulse on a tick unless suppressed after a counter write
    st_nxt.match = tick && (count == cmp) && !blk;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign match_r = st_r.match;

endmodule
`default_nettype wire

// *** t16_access_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module t16_chk (
  // Control
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        t3_tick,
  input wire logic        bus_io,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  // Byte data
  input wire logic [7:0]  bus_addr,
  input wire logic [7:0]  bus_wdata,
  input wire logic [7:0]  bus_rdata_r,
  // Read valid, timer and compare outputs
  input wire logic        bus_rvalid_r,
  input wire logic        t3_match_a_r,
  input wire logic [15:0] t3_count_r,
  input wire logic [15:0] t1_cmp_a_r,
  input wire logic [15:0] t1_cmp_b_r,
  input wire logic [15:0] t1_cmp_c_r,
  input wire logic [15:0] t3_cmp_a_r
);
  logic wlo, hit, pend_r;
  assign wlo = bus_wr && !bus_io && bus_addr == 8'h88;
  assign hit = t3_tick && !pend_r && t3_count_r == t3_cmp_a_r;
  // Counter write pending until next tick
  always_ff @(posedge core_clk) begin
    if (!rst_n)
      pend_r <= 1'b0;
    else if (ce)
      pend_r <= wlo || (pend_r && !t3_tick);
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rv; ce |=> bus_rvalid_r == $past(bus_rd); endproperty
  a_rv: assert property (p_rv) else $error("read valid wrong");
  property p_io_hi; ce && bus_wr && bus_io && bus_addr > 8'h3F |=> $stable({t1_cmp_a_r, t1_cmp_b_r}); endproperty
  a_io_hi: assert property (p_io_hi) else $error("io write above range");
  property p_ext; bus_wr && bus_io |=> $stable({t1_cmp_c_r, t3_cmp_a_r}); endproperty
  a_ext: assert property (p_ext) else $error("extended reg via io");
  property p_cmpa; ce && bus_wr && (bus_io ? bus_addr == 8'h2A : bus_addr == 8'h4A)
    |=> t1_cmp_a_r[7:0] == $past(bus_wdata); endproperty
  a_cmpa: assert property (p_cmpa) else $error("compare a low");
  property p_cmpc; ce && bus_wr && !bus_io && bus_addr == 8'h78 |=> t1_cmp_c_r[7:0] == $past(bus_wdata); endproperty
  a_cmpc: assert property (p_cmpc) else $error("compare c low");
  property p_hi; ce && bus_wr && !bus_io && bus_addr == 8'h89 && !t3_tick |=> $stable(t3_count_r); endproperty
  a_hi: assert property (p_hi) else $error("lone high write");
  property p_lo; ce && wlo |=> t3_count_r[7:0] == $past(bus_wdata); endproperty
  a_lo: assert property (p_lo) else $error("counter low write");
  property p_blk; ce && wlo && !t3_tick ##1 ce && t3_tick |=> !t3_match_a_r; endproperty
  a_blk: assert property (p_blk) else $error("match not blocked");
  property p_match; ce && !wlo |=> t3_match_a_r == $past(hit); endproperty
  a_match: assert property (p_match) else $error("match wrong");
  c_match: cover property (t3_match_a_r);
  c_rd: cover property (bus_rvalid_r);
  c_blk: cover property (wlo ##1 t3_tick);
endmodule
bind t16_access t16_chk chk (
  .core_clk     (core_clk),
  .rst_n        (rst_n),
  .ce           (ce),
  .t3_tick      (t3_tick),
  .bus_io       (bus_io),
  .bus_wr       (bus_wr),
  .bus_rd       (bus_rd),
  .bus_addr     (bus_addr),
  .bus_wdata    (bus_wdata),
  .bus_rdata_r  (bus_rdata_r),
  .bus_rvalid_r (bus_rvalid_r),
  .t3_match_a_r (t3_match_a_r),
  .t3_count_r   (t3_count_r),
  .t1_cmp_a_r   (t1_cmp_a_r),
  .t1_cmp_b_r   (t1_cmp_b_r),
  .t1_cmp_c_r   (t1_cmp_c_r),
  .t3_cmp_a_r   (t3_cmp_a_r)
);
`default_nettype wire

// *** t16_cpu.sv ***
`timescale 1ns/1ps
`default_nettype none
module t16_cpu (
  // Clock
  input wire logic  core_clk,
  // Byte access
  output logic       bus_io, bus_wr, bus_rd,
  output logic [7:0] bus_addr, bus_wdata
);
  initial {bus_io, bus_wr, bus_rd, bus_addr, bus_wdata} = '0;
  // One byte access taken per edge
  task automatic acc(input logic w, io, input logic [7:0] a, d);
    @(posedge core_clk);
    bus_wr <= w;
    bus_rd <= !w;
    bus_io <= io;
    bus_addr <= a;
    bus_wdata <= d;
  endtask
  // Released lines scrambled
  task automatic idle();
    @(posedge core_clk);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_addr <= ~bus_addr;
    bus_wdata <= ~bus_wdata;
  endtask
endmodule
`default_nettype wire

// *** test_t16_access.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_t16_access;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic        t3_tick = 1'b0;
  logic        bus_io, bus_wr, bus_rd, bus_rvalid_r, t3_match_a_r;
  logic [7:0]  bus_addr, bus_wdata, bus_rdata_r;
  logic [15:0] t3_count_r, v, cmp_r [4], ev [4];
  logic [7:0]  exp_q [$];
  logic [7:0]  lo_a [4] = '{8'h4A, 8'h48, 8'h78, 8'h86};
  int          error_cnt, check_count, hits, i;
  integer      seed = 32'h2297;
  always #2.5 core_clk = ~core_clk;
  t16_access uut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .bus_addr(bus_addr), .bus_io(bus_io),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_r(bus_rdata_r),
    .bus_rvalid_r(bus_rvalid_r), .t3_tick(t3_tick), .t3_count_r(t3_count_r), .t3_match_a_r(t3_match_a_r),
    .t1_cmp_a_r(cmp_r[0]), .t1_cmp_b_r(cmp_r[1]), .t1_cmp_c_r(cmp_r[2]), .t3_cmp_a_r(cmp_r[3]));
  t16_cpu cpu (.core_clk(core_clk), .bus_io(bus_io), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata));
  task chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk8(input logic [7:0] got, exp);
    chk({8'h00, got}, {8'h00, exp});
  endtask
  task wr16(input logic [7:0] lo, input logic [15:0] d);
    cpu.acc(1'b1, 1'b0, lo + 8'h01, d[15:8]);
    cpu.acc(1'b1, 1'b0, lo, d[7:0]);
  endtask
  task rd16(input logic [7:0] lo, input logic [15:0] d);
    exp_q.push_back(d[7:0]);
    exp_q.push_back(d[15:8]);
    cpu.acc(1'b0, 1'b0, lo, 8'h00);
    cpu.acc(1'b0, 1'b0, lo + 8'h01, 8'h00);
  endtask
  task settle();
    cpu.idle();
    @(negedge core_clk);
  endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      t3_tick <= 1'b1;
      @(posedge core_clk);
      t3_tick <= 1'b0;
    end
  endtask
  task complete_run();
    if (error_cnt == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Read results and match pulses
  always @(posedge core_clk) begin
    if (bus_rvalid_r === 1'b1)
      chk8(bus_rdata_r, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
    if (t3_match_a_r === 1'b1)
      hits++;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 4; i++)
      chk(cmp_r[i], 16'h0000);
    rd16(8'h88, 16'h0000);
    for (i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      ev[i] = v;
      wr16(lo_a[i], v);
      settle();
      chk(cmp_r[i], v);
      rd16(lo_a[i], v);
    end
    cpu.acc(1'b1, 1'b1, 8'h2B, 8'hA5);
    cpu.acc(1'b1, 1'b1, 8'h2A, 8'h5A);
    // Above the I/O limit; plus 0x20 would alias onto compare C
    cpu.acc(1'b1, 1'b1, 8'h59, 8'hFF);
    cpu.acc(1'b1, 1'b1, 8'h58, 8'hFF);
    settle();
    chk(cmp_r[0], 16'hA55A);
    chk(cmp_r[2], ev[2]);
    cpu.acc(1'b1, 1'b0, 8'h49, 8'hC3);
    cpu.acc(1'b1, 1'b0, 8'h87, 8'h3C);
    cpu.acc(1'b1, 1'b0, 8'h48, 8'h11);
    exp_q.push_back(8'h00);
    cpu.acc(1'b0, 1'b0, 8'h50, 8'h00);
    settle();
    chk(cmp_r[1], 16'h3C11);
    chk(cmp_r[3], ev[3]);
    wr16(8'h88, 16'h1234);
    settle();
    chk(t3_count_r, 16'h1234);
    rd16(8'h88, 16'h1234);
    wr16(8'h86, 16'h0005);
    wr16(8'h88, 16'h0005);
    settle();
    tick(1);
    wr16(8'h88, 16'h0004);
    settle();
    tick(2);
    settle();
    chk(t3_count_r, 16'h0006);
    chk(16'(hits), 16'h0001);
    // Enable low: no write taken, no count
    @(posedge core_clk);
    ce <= 1'b0;
    t3_tick <= 1'b1;
    cpu.acc(1'b1, 1'b0, 8'h78, 8'h77);
    settle();
    cpu.idle();
    ce <= 1'b1;
    t3_tick <= 1'b0;
    @(negedge core_clk);
    chk(t3_count_r, 16'h0006);
    chk(cmp_r[2], ev[2]);
    // Reset again in mid-run
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk(t3_count_r, 16'h0000);
    chk(cmp_r[1], 16'h0000);
    wr16(8'h88, 16'h00C3);
    settle();
    chk(t3_count_r, 16'h00C3);
    for (i = 0; i < 20 && exp_q.size() > 0; i++)
      @(posedge core_clk);
    if (exp_q.size() > 0)
      error_cnt++;
    complete_run();
  end
endmodule
`default_nettype wire
